// file: design/tca_top.sv
// Compact timer core with byte-buffered counter and comparator A access.
// Assumes an AXI4-Lite master on aclk and asynchronous timer pins.
//
// Functional notes
// - The counter is compared with programmed values and a match raises an interrupt.
// - Comparator A and comparator P each have their own interrupt source.
// - A three-bit field selects the counter clock among internal ratios, the subsidiary clock and the pin.
// - The external pin clocks the counter on a selectable rising or falling edge.
// - In compare mode a comparator A match drives output A low, high or toggled, output B the opposite.
// - The same two outputs carry a single edge-aligned PWM wave of set duty or period.
// - Counter and comparator A split into bytes; low bytes pass via one 8-bit buffer.
// - Writing the comparator A low byte only loads the buffer.
// - Writing the comparator A high byte stores it and copies the buffer to the low byte.
// - Reading a high byte returns it and captures its low byte into the buffer.
// - Reading a low byte returns the buffer, not the live low byte.
// - The counter is 10 bits counting up; P checks the top 3 bits, A all 10.
// - Clock codes: sys/4, sys, fh/16, fh/64, sub, sub, pin rising, pin falling.
// - The counter clears on run enable rising, overflow or selected match only.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tca_cfg.svh"
module tca_top (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Timer pins
   input  wire logic        timer_ext_clock_in,
   input  wire logic        timer_sub_clock_in,
   output logic             timer_out_a,
   output logic             timer_out_b,
   // Interrupt
   output logic             irq
);
   tca_pkg::tca_ctrl0_t c0;
   tca_pkg::tca_ctrl1_t c1;
   tca_pkg::tca_irq_t   status;
   tca_pkg::tca_irq_t   mask;
   logic [9:0]          count;
   logic [9:0]          compare_a_value;
   logic [7:0]          lo_buf;
   logic                run_q;
   logic                out_lvl;
   logic                tick;
   logic [7:0]          aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                wr_fire;
   logic                ar_fire;
   logic [31:0]         rd_val;
   logic                rd_ok;
   logic                wr_ok;
   logic [10:0]         inc;
   logic                run_rise;
   logic                step;
   logic                a_hit;
   logic                p_hit;
   logic                clr_sel_a;
   logic                ev_a;
   logic                ev_p;
   logic                duty_on;

   // ----------------------------------------------------------------
   // Counter clock source
   // ----------------------------------------------------------------
   tca_tick_gen #(
      .PRE_W(`TCA_LOG_H64)
   ) u_tick (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .clk_sel    (c0.timer_clk_select),
      .ext_clk_in (timer_ext_clock_in),
      .sub_clk_in (timer_sub_clock_in),
      .tick       (tick)
   );

   // ----------------------------------------------------------------
   // Counter and comparators
   // ----------------------------------------------------------------
   assign inc      = {1'b0, count} + 11'h001;
   assign run_rise = c0.timer_run_enable & ~run_q;
   assign step     = c0.timer_run_enable & ~c0.pause & tick;
   // P value zero means a full 1024-count period, i.e. overflow
   assign p_hit = (c0.compare_p_value == 3'h0) ? inc[10] :
                  (inc[9:7] == c0.compare_p_value) && (inc[6:0] == 7'h00);
   assign a_hit = (inc[9:0] == compare_a_value);
   // In PWM the duty/period swap decides which comparator ends the period
   assign clr_sel_a = (c1.mode == tca_pkg::TCA_MODE_PWM) ? c1.duty_by_p : c1.clear_on_a;
   assign ev_a = step & a_hit;
   assign ev_p = step & p_hit;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q <= 1'b0;
         count <= 10'h000;
      end else begin
         run_q <= c0.timer_run_enable;
         if (run_rise) begin
            count <= 10'h000;
         end else if (step) begin
            count <= (clr_sel_a ? a_hit : p_hit) ? 10'h000 : inc[9:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------
   assign duty_on = c1.duty_by_p ? (count[9:7] < c0.compare_p_value)
                                 : (count < compare_a_value);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_lvl <= 1'b0;
      end else if (run_rise) begin
         out_lvl <= c1.out_init;
      end else begin
         case (c1.mode)
            tca_pkg::TCA_MODE_CMP: begin
               if (ev_a) begin
                  case (c1.out_func)
                     2'b01:   out_lvl <= 1'b0;
                     2'b10:   out_lvl <= 1'b1;
                     2'b11:   out_lvl <= ~out_lvl;
                     default: out_lvl <= out_lvl;
                  endcase
               end
            end
            tca_pkg::TCA_MODE_PWM: begin
               case (c1.out_func)
                  2'b00:   out_lvl <= ~c1.out_init;
                  2'b01:   out_lvl <= c1.out_init;
                  2'b10:   out_lvl <= duty_on ? c1.out_init : ~c1.out_init;
                  default: out_lvl <= out_lvl;
               endcase
            end
            default: out_lvl <= out_lvl;
         endcase
      end
   end

   // Second pin is the complement, so it carries the inverted waveform
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_out_a <= 1'b0;
         timer_out_b <= 1'b1;
      end else begin
         timer_out_a <= out_lvl ^ c1.out_pol;
         timer_out_b <= ~(out_lvl ^ c1.out_pol);
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= 2'b00;
         irq    <= 1'b0;
      end else begin
         // A set in the same cycle as the clearing read wins
         status.a <= ev_a | (status.a & ~(ar_fire && araddr == `TCA_OFF_STATUS));
         status.p <= ev_p | (status.p & ~(ar_fire && araddr == `TCA_OFF_STATUS));
         irq      <= |(status & mask);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = ~awready & ~wready & ~bvalid;
   assign wr_ok   = (aw_addr[1:0] == 2'b00) && (aw_addr <= `TCA_OFF_MASK);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= `TCA_RESP_OKAY;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_fire) begin
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? `TCA_RESP_OKAY : `TCA_RESP_SLVERR;
            awready <= 1'b1;
            wready  <= 1'b1;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Control, mask and comparator A; only byte lane 0 carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c0              <= `TCA_RST_CTRL;
         c1              <= `TCA_RST_CTRL;
         mask            <= 2'b00;
         compare_a_value <= `TCA_RST_CMPA;
      end else if (wr_fire && w_strb[0]) begin
         case (aw_addr)
            `TCA_OFF_CTRL0:   c0   <= w_data[7:0];
            `TCA_OFF_CTRL1:   c1   <= w_data[7:0];
            `TCA_OFF_MASK:    mask <= w_data[1:0];
            `TCA_OFF_CMPA_HI: compare_a_value <= {w_data[1:0], lo_buf};
            default:          compare_a_value <= compare_a_value;
         endcase
      end
   end

   // Shared low-byte buffer; a read capture in the same cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lo_buf <= `TCA_RST_BYTE;
      end else if (ar_fire && araddr == `TCA_OFF_CNT_HI) begin
         lo_buf <= count[7:0];
      end else if (ar_fire && araddr == `TCA_OFF_CMPA_HI) begin
         lo_buf <= compare_a_value[7:0];
      end else if (wr_fire && w_strb[0] && aw_addr == `TCA_OFF_CMPA_LO) begin
         lo_buf <= w_data[7:0];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign ar_fire = arvalid & arready;
   assign rd_ok   = (araddr[1:0] == 2'b00) && (araddr <= `TCA_OFF_MASK);

   always_comb begin
      case (araddr)
         `TCA_OFF_CTRL0:   rd_val = {24'h000000, c0};
         `TCA_OFF_CTRL1:   rd_val = {24'h000000, c1};
         `TCA_OFF_CNT_LO,
         `TCA_OFF_CMPA_LO: rd_val = {24'h000000, lo_buf};
         `TCA_OFF_CNT_HI:  rd_val = {30'h00000000, count[9:8]};
         `TCA_OFF_CMPA_HI: rd_val = {30'h00000000, compare_a_value[9:8]};
         `TCA_OFF_STATUS:  rd_val = {30'h00000000, status};
         `TCA_OFF_MASK:    rd_val = {30'h00000000, mask};
         default:          rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `TCA_RESP_OKAY;
      end else if (ar_fire) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_val;
         rresp   <= rd_ok ? `TCA_RESP_OKAY : `TCA_RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd(logic [7:0] a);
      ar_fire && araddr == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      wr_fire && w_strb[0] && aw_addr == a;
   endsequence

   a_run_clears_count: assert property (
      run_rise |=> count == 10'h000) else $error("count not cleared on run enable");
   a_match_a_flag: assert property (
      ev_a |=> status.a) else $error("comparator A match lost");
   a_match_p_flag: assert property (
      ev_p ##1 !(ar_fire && araddr == `TCA_OFF_STATUS) |=> status.p)
      else $error("comparator P flag not sticky");
   a_lo_write_buf: assert property (
      s_wr(`TCA_OFF_CMPA_LO) |=> compare_a_value == $past(compare_a_value))
      else $error("low write changed comparator");
   a_hi_write_copy: assert property (
      s_wr(`TCA_OFF_CMPA_HI) |=> compare_a_value == {$past(w_data[1:0]), $past(lo_buf)})
      else $error("high write did not merge buffer");
   a_hi_read_capture: assert property (
      s_rd(`TCA_OFF_CNT_HI) |=> lo_buf == $past(count[7:0]) && rvalid
      && rdata == {30'h00000000, $past(count[9:8])}) else $error("high read capture wrong");
   a_lo_read_buf: assert property (
      s_rd(`TCA_OFF_CMPA_LO) |=> rdata == {24'h000000, $past(lo_buf)})
      else $error("low read not from buffer");
   a_count_hold: assert property (
      !step && !run_rise |=> count == $past(count)) else $error("counter moved without tick");
   a_cmp_set_high: assert property (
      c1.mode == tca_pkg::TCA_MODE_CMP && c1.out_func == 2'b10 && ev_a && !run_rise
      && $stable(c1) [*1] ##2 $stable(c1) |-> timer_out_a == ~c1.out_pol)
      else $error("compare set-high not driven");
endmodule

// file: design/tca_cfg.svh
// Register offsets, reset values and prescaler figures of the compact timer.
// Assumes a byte-addressed AXI4-Lite slave with one 32-bit word per register.
`ifndef TCA_CFG_SVH
`define TCA_CFG_SVH
`define TCA_OFF_CTRL0   8'h00
`define TCA_OFF_CTRL1   8'h04
`define TCA_OFF_CNT_LO  8'h08
`define TCA_OFF_CNT_HI  8'h0c
`define TCA_OFF_CMPA_LO 8'h10
`define TCA_OFF_CMPA_HI 8'h14
`define TCA_OFF_STATUS  8'h18
`define TCA_OFF_MASK    8'h1c
`define TCA_RST_CTRL    8'h00
`define TCA_RST_CMPA    10'h000
`define TCA_RST_BYTE    8'h00
// Prescaler taps as log2 of the ratio: fsys/4, fh/16, fh/64
`define TCA_LOG_SYS4    2
`define TCA_LOG_H16     4
`define TCA_LOG_H64     6
`define TCA_RESP_OKAY   2'b00
`define TCA_RESP_SLVERR 2'b10
`endif

// file: design/tca_pkg.sv
// Types shared by the compact timer core and its tick generator.
// Assumes nothing beyond a SystemVerilog compiler.
package tca_pkg;
   typedef enum logic [1:0] {
      TCA_MODE_CMP   = 2'b00,
      TCA_MODE_UNDEF = 2'b01,
      TCA_MODE_PWM   = 2'b10,
      TCA_MODE_TIMER = 2'b11
   } tca_mode_t;
   typedef enum logic [2:0] {
      TCA_CS_SYS4 = 3'b000,
      TCA_CS_SYS  = 3'b001,
      TCA_CS_H16  = 3'b010,
      TCA_CS_H64  = 3'b011,
      TCA_CS_SUB0 = 3'b100,
      TCA_CS_SUB1 = 3'b101,
      TCA_CS_RISE = 3'b110,
      TCA_CS_FALL = 3'b111
   } tca_clk_sel_t;
   typedef struct packed {
      logic         pause;
      tca_clk_sel_t timer_clk_select;
      logic         timer_run_enable;
      logic [2:0]   compare_p_value;
   } tca_ctrl0_t;
   typedef struct packed {
      tca_mode_t  mode;
      logic [1:0] out_func;
      logic       out_init;
      logic       out_pol;
      logic       duty_by_p;
      logic       clear_on_a;
   } tca_ctrl1_t;
   typedef struct packed {
      logic p;
      logic a;
   } tca_irq_t;
endpackage

// file: design/tca_tick_gen.sv
// Count-enable generator: prescaler taps, subsidiary clock and external pin.
// Assumes fh equals the system clock; pins are asynchronous to aclk.
`timescale 1ns/1ps
`include "tca_cfg.svh"
module tca_tick_gen #(
   parameter int PRE_W = 6
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Selection and sources
   input  wire tca_pkg::tca_clk_sel_t clk_sel,
   input  wire logic                  ext_clk_in,
   input  wire logic                  sub_clk_in,
   // One-cycle count enable
   output logic                       tick
);
   logic [PRE_W-1:0] pre;
   logic [2:0]       ext_sync;
   logic [2:0]       sub_sync;
   logic             next_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre <= '0;
      end else begin
         pre <= pre + PRE_W'(1);
      end
   end

   // Bit 0 feeds only bit 1; edges are taken between bits 1 and 2
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync <= 3'h0;
         sub_sync <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], ext_clk_in};
         sub_sync <= {sub_sync[1:0], sub_clk_in};
      end
   end

   always_comb begin
      case (clk_sel)
         tca_pkg::TCA_CS_SYS4: next_tick = &pre[`TCA_LOG_SYS4-1:0];
         tca_pkg::TCA_CS_SYS:  next_tick = 1'b1;
         tca_pkg::TCA_CS_H16:  next_tick = &pre[`TCA_LOG_H16-1:0];
         tca_pkg::TCA_CS_H64:  next_tick = &pre[`TCA_LOG_H64-1:0];
         tca_pkg::TCA_CS_SUB0,
         tca_pkg::TCA_CS_SUB1: next_tick = sub_sync[1] & ~sub_sync[2];
         tca_pkg::TCA_CS_RISE: next_tick = ext_sync[1] & ~ext_sync[2];
         tca_pkg::TCA_CS_FALL: next_tick = ~ext_sync[1] & ext_sync[2];
         default:              next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick <= 1'b0;
      end else begin
         tick <= next_tick;
      end
   end
endmodule

// file: test/tca_pin_model.sv
// Far-side model of the timer pins: external count source and subsidiary clock.
// Assumes the bench calls pulse from its own thread; pins are async to aclk.
`timescale 1ns/1ps
module tca_pin_model (
   // Timer input pins
   output logic ext_clk,
   output logic sub_clk
);
   initial begin
      ext_clk = 1'b0;
      sub_clk = 1'b0;
   end

   // Subsidiary oscillator runs free at 10 MHz, unrelated in phase to aclk
   always #50 sub_clk = ~sub_clk;

   // Each pulse gives one rising and one falling edge, wide enough for the synchroniser
   task automatic pulse(input int n);
      // Start off the aclk edge so no pin transition races a synchroniser sample
      #2;
      repeat (n) begin
         #40 ext_clk = 1'b1;
         #40 ext_clk = 1'b0;
      end
   endtask
endmodule

// file: test/tca_top_tb.sv
// Self-checking bench for tca_top: AXI4-Lite register tasks and timer scenarios.
// Assumes tca_pin_model as far side and a 100 MHz aclk.
`timescale 1ns/1ps
`include "tca_cfg.svh"
module tca_top_tb;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, val;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        ext_clk, sub_clk, out_a, out_b, irq, init;
   logic [9:0]  v10;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          hi_cnt, bad_b;
   int          ratio [6] = '{4, 1, 16, 64, 10, 10};
   logic [7:0]  offs [6] = '{`TCA_OFF_CTRL0, `TCA_OFF_CTRL1, `TCA_OFF_CNT_HI,
                             `TCA_OFF_CMPA_HI, `TCA_OFF_STATUS, `TCA_OFF_MASK};

   tca_top dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .timer_ext_clock_in(ext_clk),
      .timer_sub_clock_in(sub_clk), .timer_out_a(out_a), .timer_out_b(out_b), .irq(irq));
   tca_pin_model pins (.ext_clk(ext_clk), .sub_clk(sub_clk));

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   // ----------------------------------------
   // Bus tasks and comparisons
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic near(input string what, input int exp, input int got, input int tol);
      tests_run++;
      if (got > exp + tol || got < exp - tol) begin
         error_cnt++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // A valid drops only at the edge that takes it, so a following call may raise it again
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d    = rdata;
      resp = rresp;
   endtask

   // High byte first, then the buffered low byte
   task automatic rd10(input logic [7:0] hi, output logic [9:0] v);
      logic [31:0] h, l;
      rd(hi, h);
      check("high byte unused bits", 32'h0, {h[31:2], 2'b00});
      rd(hi - 8'h04, l);
      v = {h[1:0], l[7:0]};
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge aclk);
      error_cnt++;
      summarize();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      arvalid = 1'b0;
      bready  = 1'b1;
      rready  = 1'b1;
      awaddr  = 8'h00;
      araddr  = 8'h00;
      wdata   = 32'h0;
      wstrb   = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("out_b at reset", 32'h1, 32'(out_b));
      foreach (offs[i]) begin
         rd(offs[i], val);
         check("reset value", 32'h0, val);
      end
      rd(8'h20, val);
      check("unmapped rresp", 32'(`TCA_RESP_SLVERR), 32'(resp));
      wr(8'h24, 8'hff);
      check("unmapped bresp", 32'(`TCA_RESP_SLVERR), 32'(resp));
      $display("test reset and map done");

      wr(`TCA_OFF_CMPA_LO, 8'h5a);
      rd10(`TCA_OFF_CMPA_HI, v10);
      check("cmpa before high write", 32'h0, 32'(v10));
      wr(`TCA_OFF_CMPA_LO, 8'h5a);
      wr(`TCA_OFF_CMPA_HI, 8'hff);
      check("mapped bresp", 32'(`TCA_RESP_OKAY), 32'(resp));
      wr(`TCA_OFF_CMPA_LO, 8'h11);
      rd(`TCA_OFF_CMPA_LO, val);
      check("buffer read", 32'h11, val);
      check("mapped rresp", 32'(`TCA_RESP_OKAY), 32'(resp));
      rd10(`TCA_OFF_CMPA_HI, v10);
      check("cmpa word", 32'h35a, 32'(v10));
      wstrb <= 4'he;
      wr(`TCA_OFF_CMPA_HI, 8'h00);
      wstrb <= 4'hf;
      check("masked write bresp", 32'(`TCA_RESP_OKAY), 32'(resp));
      rd10(`TCA_OFF_CMPA_HI, v10);
      check("cmpa after masked write", 32'h35a, 32'(v10));
      $display("test byte buffer done");

      wr(`TCA_OFF_CTRL0, 8'h68);
      pins.pulse(4);
      repeat (6) @(posedge aclk);
      rd10(`TCA_OFF_CNT_HI, v10);
      check("rising edge count", 32'h4, 32'(v10));
      wr(`TCA_OFF_CTRL0, 8'h70);
      wr(`TCA_OFF_CTRL0, 8'h78);
      pins.pulse(3);
      repeat (6) @(posedge aclk);
      rd10(`TCA_OFF_CNT_HI, v10);
      check("falling edge count", 32'h3, 32'(v10));
      $display("test external pin done");

      // Internal and subsidiary sources: 600 cycles per code, tolerance covers prescaler phase
      foreach (ratio[c]) begin
         wr(`TCA_OFF_CTRL0, {1'b0, 3'(c), 4'h0});
         wr(`TCA_OFF_CTRL0, {1'b0, 3'(c), 4'h8});
         repeat (600) @(posedge aclk);
         rd10(`TCA_OFF_CNT_HI, v10);
         near("count rate", 600 / ratio[c], int'(v10), 4);
      end
      $display("test clock select done");

      wr(`TCA_OFF_CMPA_LO, 8'h05);
      wr(`TCA_OFF_CMPA_HI, 8'h00);
      for (int f = 1; f < 4; f++) begin
         init = (f == 1);
         wr(`TCA_OFF_MASK, {7'h00, f != 2});
         wr(`TCA_OFF_CTRL0, 8'h60);
         wr(`TCA_OFF_CTRL1, {2'b00, 2'(f), init, 3'b001});
         wr(`TCA_OFF_CTRL0, 8'h68);
         repeat (2) @(posedge aclk);
         check("out_a initial", 32'(init), 32'(out_a));
         pins.pulse(5);
         repeat (8) @(posedge aclk);
         check("out_a on match", 32'(f != 1), 32'(out_a));
         check("out_b on match", 32'(f == 1), 32'(out_b));
         check("irq on match", 32'(f != 2), 32'(irq));
         rd(`TCA_OFF_STATUS, val);
         check("status A", 32'h1, val);
         repeat (3) @(posedge aclk);
         check("irq after read", 32'h0, 32'(irq));
      end
      $display("test compare output done");

      wr(`TCA_OFF_MASK, 8'h02);
      wr(`TCA_OFF_CTRL1, 8'h00);
      wr(`TCA_OFF_CTRL0, 8'h10);
      wr(`TCA_OFF_CTRL0, 8'h19);
      repeat (100) @(posedge aclk);
      check("irq before P match", 32'h0, 32'(irq));
      repeat (100) @(posedge aclk);
      check("irq after P match", 32'h1, 32'(irq));
      rd(`TCA_OFF_STATUS, val);
      check("status A and P", 32'h3, val);
      $display("test comparator P done");

      // PWM: period 128 from P, duty while count below 32, active high
      wr(`TCA_OFF_CTRL0, 8'h10);
      wr(`TCA_OFF_CTRL1, 8'ha8);
      wr(`TCA_OFF_CMPA_LO, 8'h20);
      wr(`TCA_OFF_CMPA_HI, 8'h00);
      wr(`TCA_OFF_CTRL0, 8'h19);
      repeat (20) @(posedge aclk);
      hi_cnt = 0;
      bad_b  = 0;
      repeat (256) begin
         @(posedge aclk);
         hi_cnt += int'(out_a);
         if (out_b === out_a) bad_b++;
      end
      near("pwm high cycles", 64, hi_cnt, 3);
      check("pwm out_b complement", 32'h0, 32'(bad_b));
      $display("test pwm done");
      summarize();
   end
endmodule
